// [logic/vas_pkg.sv]
// Purpose: Shared constants and types for the vibration alarm sequencer.
// Assumes: 50 MHz system clock, 1 ms time base.
// Notes:   All phase timing is counted in milliseconds.
package vas_pkg;

  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned MS_PER_S     = 1000;
  localparam int unsigned BUZ_HZ_DEF   = 2500;

  // Times in milliseconds
  localparam int unsigned STANDBY_MS   = 10000;
  localparam int unsigned STBY_PER_MS  = 50;
  localparam int unsigned ALARM_MS     = 20000;
  localparam int unsigned ALARM_PER_MS = 500;
  localparam int unsigned WAKE_MS      = 3280;
  localparam int unsigned HEART_MS     = 10;

  typedef logic [14:0] vas_ms_t;

  localparam vas_ms_t STANDBY_LAST  = vas_ms_t'(STANDBY_MS - 1);
  localparam vas_ms_t STBY_HALF     = vas_ms_t'(STBY_PER_MS / 2 - 1);
  localparam vas_ms_t ALARM_LAST    = vas_ms_t'(ALARM_MS - 1);
  localparam vas_ms_t ALARM_HALF    = vas_ms_t'(ALARM_PER_MS / 2 - 1);
  localparam vas_ms_t WAKE_LAST     = vas_ms_t'(WAKE_MS - 1);
  localparam vas_ms_t HEART_LAST    = vas_ms_t'(HEART_MS - 1);
  localparam vas_ms_t MS_ZERO       = 15'h0000;
  localparam vas_ms_t MS_ONE        = 15'h0001;

  localparam logic LED_ON   = 1'b0;
  localparam logic LED_OFF  = 1'b1;
  localparam logic BUZ_IDLE = 1'b0;

  typedef enum logic [1:0] {
    VAS_STANDBY = 2'h0,
    VAS_SLEEP   = 2'h1,
    VAS_ALARM   = 2'h3,
    VAS_HEART   = 2'h2
  } vas_state_t;

endpackage : vas_pkg

// [logic/vas_tick_if.sv]
// Purpose: Carries the time base enables from divider to sequencer.
// Assumes: Single clock domain.
// Notes:   Both signals are one-cycle enable pulses.
`timescale 1ns/100ps
`default_nettype none
interface vas_tick_if;
  logic ms_tick;
  logic buz_tick;
  modport src (output ms_tick, output buz_tick);
  modport dst (input  ms_tick, input  buz_tick);
endinterface : vas_tick_if
`default_nettype wire

// [logic/vas_timebase.sv]
// Purpose: Free-running 1 ms tick and buzzer half-period tick.
// Assumes: Counts given in system clock cycles.
// Notes:   Runs from reset, never gated.
`timescale 1ns/100ps
`default_nettype none
module vas_timebase
  import vas_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S,
  parameter int unsigned BUZ_HALF    = CLK_HZ / (2 * BUZ_HZ_DEF)
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  vas_tick_if.src   tick
);

  logic [15:0] ms_cnt_r;
  logic [15:0] ms_cnt_nxt;
  logic [15:0] buz_cnt_r;
  logic [15:0] buz_cnt_nxt;
  logic        ms_hit;
  logic        buz_hit;

  always_comb begin
    ms_hit      = (ms_cnt_r == 16'(TICK_CYCLES - 1)); // [RULE9]
    buz_hit     = (buz_cnt_r == 16'(BUZ_HALF - 1));
    ms_cnt_nxt  = ms_hit  ? 16'h0000 : ms_cnt_r + 16'h0001;
    buz_cnt_nxt = buz_hit ? 16'h0000 : buz_cnt_r + 16'h0001;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ms_cnt_r  <= 16'h0000;
      buz_cnt_r <= 16'h0000;
    end else begin
      ms_cnt_r  <= ms_cnt_nxt;
      buz_cnt_r <= buz_cnt_nxt;
    end
  end

  assign tick.ms_tick  = ms_hit;
  assign tick.buz_tick = buz_hit;

endmodule : vas_timebase
`default_nettype wire

// [logic/vas_sequencer.sv]
// Purpose: Window vibration alarm sequencer (standby, sleep, alarm, beat).
// Assumes: 50 MHz clk_i, vibration input asynchronous to it.
// Notes:   LED pin is active low; buzzer idles low.
// Behaviour
// (RULE1) After reset the LED toggles with a 50 ms cycle for 10 s of standby.
// (RULE2) Vibration is ignored until the 10 s standby has ended.
// (RULE3) When idle the block sleeps and wakes only on vibration or watchdog.
// (RULE4) A vibration while armed starts an alarm with buzzer active for 20 s.
// (RULE5) During the alarm the LED toggles with a 500 ms cycle for 20 s.
// (RULE6) Without alarm it wakes about every 3.28 s for a short LED blink.
// (RULE7) Outside standby, alarm and heartbeat blinks the LED is held off.
// (RULE8) When the alarm ends, buzzer and LED stop, sensing re-arms, sleep.
// (RULE9) All phase timing derives from a free-running 1 ms tick; the buzzer has its own half-period tick.
// (RULE10) The buzzer carries a square wave in alarm and idles otherwise.
// (RULE11) The LED pin is active low.
// (RULE12) The sensor gives a high pulse that drops when vibration stops.
// (RULE13) The vibration input is synchronised by two flops, rising edge used.
`timescale 1ns/100ps
`default_nettype none
module vas_sequencer
  import vas_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S,
  parameter int unsigned BUZ_HZ      = BUZ_HZ_DEF
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic vibration_irq_input_i,
  output logic      alarm_led_pin_o,
  output logic      buzzer_wave_output_o,
  output logic      sensing_active_o,
  output logic      sleep_o
);

  //////////////////////////////////////////////////////////////////////////////

  vas_tick_if tick ();

  vas_timebase #(
    .TICK_CYCLES (TICK_CYCLES),
    .BUZ_HALF    (CLK_HZ / (2 * BUZ_HZ))
  ) u_timebase (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tick    (tick)
  );

  //////////////////////////////////////////////////////////////////////////////

  // Terminal count compare, shared by every phase counter
  function automatic logic ms_last(input vas_ms_t cnt, input vas_ms_t last);
    ms_last = (cnt == last);
  endfunction : ms_last

  vas_state_t state_r;
  vas_state_t state_nxt;
  vas_ms_t    phase_r;
  vas_ms_t    phase_nxt;
  vas_ms_t    blink_r;
  vas_ms_t    blink_nxt;
  vas_ms_t    wdt_r;
  vas_ms_t    wdt_nxt;
  logic       led_r;
  logic       led_nxt;
  logic       buz_r;
  logic       buz_nxt;
  logic       vib_s1_r;
  logic       vib_s2_r;
  logic       vib_s3_r;
  logic       vib_evt;
  logic       wake_evt;
  logic       sensing_r;
  logic       sensing_nxt;
  logic       sleep_r;
  logic       sleep_nxt;

  // The second and third stages feed the edge detector
  assign vib_evt = vib_s2_r & ~vib_s3_r; // [RULE13] [RULE12]

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vib_s1_r <= 1'b0;
      vib_s2_r <= 1'b0;
      vib_s3_r <= 1'b0;
    end else begin
      vib_s1_r <= vibration_irq_input_i; // [RULE13]
      vib_s2_r <= vib_s1_r;
      vib_s3_r <= vib_s2_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // Watchdog keeps counting through sleep and heartbeat, as it would in stop
  always_comb begin
    wdt_nxt  = wdt_r;
    wake_evt = 1'b0;
    if (state_r == VAS_STANDBY || state_r == VAS_ALARM) begin
      wdt_nxt = MS_ZERO;
    end else if (tick.ms_tick) begin
      if (ms_last(wdt_r, WAKE_LAST)) begin // [RULE6]
        wdt_nxt  = MS_ZERO;
        wake_evt = 1'b1;
      end else begin
        wdt_nxt = wdt_r + MS_ONE;
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    blink_nxt = blink_r;
    led_nxt   = led_r;
    buz_nxt   = BUZ_IDLE;
    case (state_r)
      VAS_STANDBY: begin
        // Vibration edges are simply dropped here
        if (tick.ms_tick) begin // [RULE9]
          blink_nxt = blink_r + MS_ONE;
          phase_nxt = phase_r + MS_ONE;
          if (ms_last(blink_r, STBY_HALF)) begin
            blink_nxt = MS_ZERO;
            led_nxt   = ~led_r; // [RULE1]
          end
          if (ms_last(phase_r, STANDBY_LAST)) begin // [RULE2]
            state_nxt = VAS_SLEEP;
            phase_nxt = MS_ZERO;
            blink_nxt = MS_ZERO;
            led_nxt   = LED_OFF; // [RULE7]
          end
        end
      end
      VAS_SLEEP: begin
        led_nxt = LED_OFF; // [RULE7] [RULE11]
        if (vib_evt) begin // [RULE3] [RULE4]
          state_nxt = VAS_ALARM;
          phase_nxt = MS_ZERO;
          blink_nxt = MS_ZERO;
          led_nxt   = LED_ON;
        end else if (wake_evt) begin // [RULE3] [RULE6]
          state_nxt = VAS_HEART;
          phase_nxt = MS_ZERO;
          led_nxt   = LED_ON;
        end
      end
      VAS_HEART: begin
        if (vib_evt) begin // [RULE4]
          state_nxt = VAS_ALARM;
          phase_nxt = MS_ZERO;
          blink_nxt = MS_ZERO;
          led_nxt   = LED_ON;
        end else if (tick.ms_tick) begin
          phase_nxt = phase_r + MS_ONE;
          if (ms_last(phase_r, HEART_LAST)) begin // [RULE6]
            state_nxt = VAS_SLEEP;
            phase_nxt = MS_ZERO;
            led_nxt   = LED_OFF; // [RULE7]
          end
        end
      end
      VAS_ALARM: begin
        // Further vibration while sounding does not restart the 20 s
        buz_nxt = tick.buz_tick ? ~buz_r : buz_r; // [RULE10]
        if (tick.ms_tick) begin
          blink_nxt = blink_r + MS_ONE;
          phase_nxt = phase_r + MS_ONE;
          if (ms_last(blink_r, ALARM_HALF)) begin
            blink_nxt = MS_ZERO;
            led_nxt   = ~led_r; // [RULE5]
          end
          if (ms_last(phase_r, ALARM_LAST)) begin // [RULE4] [RULE8]
            state_nxt = VAS_SLEEP;
            phase_nxt = MS_ZERO;
            blink_nxt = MS_ZERO;
            led_nxt   = LED_OFF;
            buz_nxt   = BUZ_IDLE; // [RULE10]
          end
        end
      end
      default: begin
        state_nxt = VAS_SLEEP;
        led_nxt   = LED_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= VAS_STANDBY; // [RULE1]
      phase_r <= MS_ZERO;
      blink_r <= MS_ZERO;
      wdt_r   <= MS_ZERO;
      led_r   <= LED_ON;
      buz_r   <= BUZ_IDLE;
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      blink_r <= blink_nxt;
      wdt_r   <= wdt_nxt;
      led_r   <= led_nxt;
      buz_r   <= buz_nxt;
    end
  end

  // Status pins from flops, so state decode never glitches onto them
  always_comb begin
    sensing_nxt = (state_nxt == VAS_SLEEP) ||
                  (state_nxt == VAS_HEART); // [RULE2]
    sleep_nxt   = (state_nxt == VAS_SLEEP); // [RULE3]
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sensing_r <= 1'b0;
      sleep_r   <= 1'b0;
    end else begin
      sensing_r <= sensing_nxt;
      sleep_r   <= sleep_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  assign alarm_led_pin_o      = led_r; // [RULE11]
  assign buzzer_wave_output_o = buz_r;
  assign sensing_active_o     = sensing_r; // [RULE2]
  assign sleep_o              = sleep_r;

endmodule : vas_sequencer
`default_nettype wire

// [tb/vas_props.sv]
// Purpose: Pin timing checks on the alarm sequencer.
// Assumes: Phase decoded from the two status outputs.
// Notes:   Spans allow two cycles of slack.
`timescale 1ns/100ps
`default_nettype none
module vas_props
  import vas_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S,
  parameter int unsigned BUZ_HZ      = BUZ_HZ_DEF
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic vibration_irq_input_i,
  input wire logic alarm_led_pin_o,
  input wire logic buzzer_wave_output_o,
  input wire logic sensing_active_o,
  input wire logic sleep_o
);
  localparam int SH = STBY_PER_MS / 2 * TICK_CYCLES;
  localparam int AH = ALARM_PER_MS / 2 * TICK_CYCLES;
  localparam int AL = ALARM_MS * TICK_CYCLES;
  localparam int HB = HEART_MS * TICK_CYCLES;
  localparam int BH = CLK_HZ / (2 * BUZ_HZ);
  logic armed_r;
  int   run_r;
  int   buz_r;
  int   len_r;
  wire  alarm = armed_r & ~sensing_active_o & ~sleep_o;
  wire  heart = sensing_active_o & ~sleep_o;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      armed_r <= 1'b0;
      run_r   <= 0;
      buz_r   <= 0;
      len_r   <= 0;
    end else begin
      armed_r <= armed_r | sleep_o;
      run_r   <= $changed(alarm_led_pin_o) ? 0 : run_r + 1;
      buz_r   <= (!alarm || $changed(buzzer_wave_output_o)) ? 0 : buz_r + 1;
      // Restart on alarm entry, which may follow a heartbeat directly
      len_r   <= $rose(alarm) ? 1 : ((alarm | heart) ? len_r + 1 : 0);
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_sleep_quiet: assert property (
    sleep_o |-> alarm_led_pin_o == LED_OFF && buzzer_wave_output_o == BUZ_IDLE)
    else $error("sleep not quiet");
  a_stby_deaf: assert property (
    !armed_r && !sleep_o
    |-> !sensing_active_o && buzzer_wave_output_o == BUZ_IDLE)
    else $error("sensing during standby");
  a_vib_wakes: assert property (
    $rose(vibration_irq_input_i) && sensing_active_o ##1 sensing_active_o
    |-> ##[1:4] alarm) else $error("vibration did not start alarm");
  a_buz_wave: assert property (
    alarm |-> buz_r <= BH + 1) else $error("buzzer static in alarm");
  a_stby_blink: assert property (
    !armed_r && !sleep_o && $changed(alarm_led_pin_o)
    |-> run_r inside {[SH-2:SH+1]}) else $error("standby blink period");
  a_alarm_blink: assert property (
    alarm && $past(alarm) && $changed(alarm_led_pin_o)
    |-> run_r inside {[AH-2:AH+1]}) else $error("alarm blink period");
  a_alarm_span: assert property (
    $fell(alarm) |-> len_r inside {[AL-2:AL+2]}) else $error("alarm length");
  a_alarm_lit: assert property (
    $rose(alarm) |-> alarm_led_pin_o == LED_ON) else $error("alarm led dark");
  a_beat_lit: assert property (
    heart |-> alarm_led_pin_o == LED_ON) else $error("heartbeat led dark");
  a_beat_span: assert property (
    $fell(heart) && sleep_o |-> len_r inside {[HB-2:HB+2]})
    else $error("heartbeat length");
  c_alarm: cover property ($rose(alarm));
  c_beat: cover property ($rose(heart));
  c_armed: cover property ($rose(armed_r));
endmodule : vas_props
bind vas_sequencer vas_props #(
  .TICK_CYCLES(TICK_CYCLES),
  .BUZ_HZ     (BUZ_HZ)
) u_vas_props (
  .clk_i                (clk_i),
  .rst_n_i              (rst_n_i),
  .vibration_irq_input_i(vibration_irq_input_i),
  .alarm_led_pin_o      (alarm_led_pin_o),
  .buzzer_wave_output_o (buzzer_wave_output_o),
  .sensing_active_o     (sensing_active_o),
  .sleep_o              (sleep_o)
);
`default_nettype wire

// [tb/vas_sensor_model.sv]
// Purpose: Vibration sensor stand-in.
// Assumes: Pulse length in clock cycles.
// Notes:   Line sits low between pulses.
`timescale 1ns/100ps
`default_nettype none
module vas_sensor_model (
  input  wire logic clk_i,
  output var  logic pulse_o
);
  initial pulse_o = 1'b0;
  task automatic shake(input int n);
    @(posedge clk_i);
    pulse_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    pulse_o <= 1'b0;
  endtask : shake
endmodule : vas_sensor_model
`default_nettype wire

// [tb/tb_vas_sequencer.sv]
// Purpose: Self-checking bench for the alarm sequencer.
// Assumes: Short 1 ms tick to keep the run small.
// Notes:   Fixed seed, random pulse timing.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  errors++; $display("BAD %s exp %0d got %0d", nm, ex, got); end end
module tb_vas_sequencer;
  import vas_pkg::*;
  localparam int TK = 2;
  localparam int BZ = 5_000_000;
  logic clk_i   = 1'b0;
  logic rst_n_i = 1'b0;
  logic vib, led, buz, sen, slp;
  int   errors = 0, check_count = 0, cyc = 0, t0, a, b;
  int   n_led = 0, n_buz = 0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) cyc++;
  always @(led) n_led++;
  always @(buz) n_buz++;
  vas_sensor_model u_vas_sensor_model (.clk_i(clk_i), .pulse_o(vib));
  vas_sequencer #(.TICK_CYCLES(TK), .BUZ_HZ(BZ)) u_vas_sequencer (
    .clk_i                (clk_i),
    .rst_n_i              (rst_n_i),
    .vibration_irq_input_i(vib),
    .alarm_led_pin_o      (led),
    .buzzer_wave_output_o (buz),
    .sensing_active_o     (sen),
    .sleep_o              (slp)
  );
  function automatic int cy(input int ms);
    return ms * TK;
  endfunction : cy
  function automatic logic near(input int got, input int ex, input int tol);
    return (got >= ex - tol) && (got <= ex + tol);
  endfunction : near
  task automatic wait_on(input logic sel, input logic v, input int lim);
    int k;
    k = 0;
    while (((sel ? sen : slp) !== v) && k < lim) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    `CHK("wait", 1'b1, k < lim)
  endtask : wait_on
  task automatic print_verdict;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  initial begin
    #(100_000 * 20);
    errors++;
    print_verdict();
  end
  initial begin
    void'($urandom(40361));
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t0 = cyc;
    a = n_led;
    b = n_buz;
    repeat (100 + $urandom % 5000) @(posedge clk_i);
    u_vas_sensor_model.shake(3 + $urandom % 20);
    wait_on(1'b0, 1'b1, cy(STANDBY_MS) + 10);
    `CHK("stby_len", 1'b1, near(cyc - t0, cy(STANDBY_MS), 3))
    `CHK("stby_buz", b, n_buz)
    `CHK("stby_led", 1'b1, near(n_led - a, STANDBY_MS / 25, 1))
    `CHK("led_off", LED_OFF, led)
    t0 = cyc;
    wait_on(1'b0, 1'b0, cy(WAKE_MS) + 10);
    `CHK("wake", 1'b1, near(cyc - t0, cy(WAKE_MS), 3))
    `CHK("beat_led", LED_ON, led)
    t0 = cyc;
    wait_on(1'b0, 1'b1, cy(HEART_MS) + 10);
    `CHK("beat_len", 1'b1, near(cyc - t0, cy(HEART_MS), 2))
    repeat ($urandom % 50) @(posedge clk_i);
    a = n_led;
    b = n_buz;
    fork
      u_vas_sensor_model.shake(3 + $urandom % 20);
    join_none
    wait_on(1'b1, 1'b0, 8);
    t0 = cyc;
    repeat (1000) @(posedge clk_i);
    u_vas_sensor_model.shake(5);
    wait_on(1'b0, 1'b1, cy(ALARM_MS) + 20);
    `CHK("alm_len", 1'b1, near(cyc - t0, cy(ALARM_MS), 4))
    `CHK("alm_led", 1'b1, near(n_led - a, ALARM_MS / 250 + 1, 1))
    `CHK("alm_buz", 1'b1, near(n_buz - b, cy(ALARM_MS) / 5, 3))
    `CHK("alm_end", {LED_OFF, BUZ_IDLE}, {led, buz})
    fork
      u_vas_sensor_model.shake(4);
    join_none
    wait_on(1'b1, 1'b0, 8);
    repeat (50) @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("rst_out", {LED_ON, 2'b00}, {led, buz, sen})
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    a = n_led;
    repeat (cy(STBY_PER_MS) + 4) @(posedge clk_i);
    `CHK("rst_blink", 2, n_led - a)
    `CHK("rst_deaf", 1'b0, sen)
    print_verdict();
  end
endmodule : tb_vas_sequencer
`default_nettype wire
